// ==== radio_seq_pkg.sv ====
// Constants and types shared by the radio power and reset sequencer
package radio_seq_pkg;

    // System clock
    localparam longint unsigned CLK_HZ          = 64'd40_000_000;

    // Times as specified, in milliseconds
    localparam longint unsigned OFF_MIN_MS      = 64'd10;
    localparam longint unsigned POR_HOLD_MAX_MS = 64'd110;
    localparam longint unsigned SDIO_WAIT_MS    = 64'd150;

    // Least times round up, longest times round down
    localparam longint unsigned OFF_MIN_CYCLES   = (OFF_MIN_MS * CLK_HZ + 64'd999) / 64'd1000;
    localparam longint unsigned POR_HOLD_CYCLES  = (POR_HOLD_MAX_MS * CLK_HZ) / 64'd1000;
    localparam longint unsigned SDIO_WAIT_CYCLES = (SDIO_WAIT_MS * CLK_HZ + 64'd999) / 64'd1000;

    // Counter width large enough for the longest wait
    localparam int unsigned     CNT_WIDTH        = 23;

    // Synchroniser depth
    localparam int unsigned     SYNC_STAGES      = 2;

    // Reset values of outputs
    localparam logic            REG_EN_RESET     = 1'b0;
    localparam logic            SECT_RSTN_RESET  = 1'b0;
    localparam logic            POR_RSTN_RESET   = 1'b0;
    localparam logic            READY_RESET      = 1'b0;
    localparam logic            EARLY_RESET      = 1'b0;

    // Power-on reset sequence
    typedef enum logic [3:0] {
        ST_OFF    = 4'b0001,
        ST_HOLD   = 4'b0010,
        ST_SETTLE = 4'b0100,
        ST_READY  = 4'b1000
    } por_state_t;

endpackage

// ==== req_sync.sv ====
// Multi-bit two-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none

module req_sync #(
    parameter int unsigned WIDTH  = 2,
    parameter int unsigned STAGES = radio_seq_pkg::SYNC_STAGES
) (
    input  wire logic             mclk,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    import radio_seq_pkg::*;

    logic [WIDTH-1:0] stage_reg [STAGES];

    // Each flop but the last is read only by the next stage; the first is never decoded
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < STAGES; i++) begin
                stage_reg[i] <= '0;
            end
        end else begin
            stage_reg[0] <= async_in;
            for (int i = 1; i < STAGES; i++) begin
                stage_reg[i] <= stage_reg[i-1];
            end
        end
    end

    assign sync_out = stage_reg[STAGES-1];

endmodule
`default_nettype wire

// ==== radio_power_reset_sequencer.sv ====
// Power and reset sequencer for the wireless and Bluetooth sections
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - WLAN request high: regulators on, WLAN released once power-on reset ends
// - WLAN request low: WLAN held in reset
// - Regulators follow OR of both requests
// - BT request low, WLAN high: BT reset
// - Power-on reset lasts at most 110 ms
module radio_power_reset_sequencer #(
    parameter int unsigned               CNT_W       = radio_seq_pkg::CNT_WIDTH,
    parameter logic [CNT_W-1:0]          POR_HOLD    = CNT_W'(radio_seq_pkg::POR_HOLD_CYCLES),
    parameter logic [CNT_W-1:0]          SDIO_WAIT   = CNT_W'(radio_seq_pkg::SDIO_WAIT_CYCLES),
    parameter logic [CNT_W-1:0]          OFF_MIN     = CNT_W'(radio_seq_pkg::OFF_MIN_CYCLES)
) (
    input  wire logic                    mclk,
    input  wire logic                    rstn,
    input  wire logic                    wlan_power_request,
    input  wire logic                    bt_power_request,
    input  wire logic                    core_supply_good,
    input  wire logic                    io_supply_good,
    output logic                         regulator_enable,
    output logic                         wlan_reset_n,
    output logic                         bt_reset_n,
    output logic                         por_reset_n,
    output logic                         sdio_ready,
    output logic                         restart_too_early
);
    import radio_seq_pkg::*;

    // Synchronised requests
    logic [1:0]       req_sync_w;
    wire logic        wl_s = req_sync_w[0];
    wire logic        bt_s = req_sync_w[1];

    req_sync #(
        .WIDTH    (2),
        .STAGES   (SYNC_STAGES)
    ) u_req_sync (
        .mclk     (mclk),
        .rstn     (rstn),
        .async_in ({bt_power_request, wlan_power_request}),
        .sync_out (req_sync_w)
    );

    // Sequence state
    por_state_t       state_reg;
    por_state_t       state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic [CNT_W-1:0] off_cnt_reg;
    logic [CNT_W-1:0] off_cnt_next;
    logic             was_on_reg;

    logic             regulator_enable_reg;
    logic             wlan_reset_n_reg;
    logic             bt_reset_n_reg;
    logic             por_reset_n_reg;
    logic             sdio_ready_reg;
    logic             restart_too_early_reg;

    // Decode
    wire logic        supplies_up  = core_supply_good & io_supply_good;
    wire logic        any_on       = wl_s | bt_s;
    wire logic        hold_done    = (cnt_reg == POR_HOLD - CNT_W'(1));
    wire logic        wait_done    = (cnt_reg == SDIO_WAIT - CNT_W'(1));
    wire logic        cnt_clear    = !supplies_up || (state_reg == ST_OFF);
    wire logic        cnt_stop     = (state_reg == ST_READY);
    wire logic        off_full     = (off_cnt_reg == OFF_MIN);
    wire logic        por_ok_next  = (state_next == ST_SETTLE) || (state_next == ST_READY);

    // Counter is shared by the reset hold and the host access wait
    assign cnt_next     = cnt_clear ? '0 : (cnt_stop ? cnt_reg : cnt_reg + CNT_W'(1));

    // Off time saturates, so a long power-down never wraps into a false alarm
    assign off_cnt_next = any_on ? '0 : (off_full ? off_cnt_reg : off_cnt_reg + CNT_W'(1));

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_OFF: begin
                if (supplies_up) begin
                    state_next = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (!supplies_up) begin
                    state_next = ST_OFF;
                end else if (hold_done) begin
                    state_next = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                if (!supplies_up) begin
                    state_next = ST_OFF;
                end else if (wait_done) begin
                    state_next = ST_READY;
                end
            end
            ST_READY: begin
                if (!supplies_up) begin
                    state_next = ST_OFF;
                end
            end
            default: begin
                state_next = ST_OFF;
            end
        endcase
    end

    // Output next values
    wire logic reg_en_next   = any_on;
    wire logic wlan_rn_next  = por_ok_next & wl_s;
    wire logic bt_rn_next    = por_ok_next & bt_s;
    wire logic ready_next    = (state_next == ST_READY);
    wire logic early_next    = any_on & !was_on_reg & !off_full;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_reg   <= ST_OFF;
            cnt_reg     <= '0;
            off_cnt_reg <= OFF_MIN;
            was_on_reg  <= 1'b0;
        end else begin
            state_reg   <= state_next;
            cnt_reg     <= cnt_next;
            off_cnt_reg <= off_cnt_next;
            was_on_reg  <= any_on;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            regulator_enable_reg  <= REG_EN_RESET;
            wlan_reset_n_reg      <= SECT_RSTN_RESET;
            bt_reset_n_reg        <= SECT_RSTN_RESET;
            por_reset_n_reg       <= POR_RSTN_RESET;
            sdio_ready_reg        <= READY_RESET;
            restart_too_early_reg <= EARLY_RESET;
        end else begin
            regulator_enable_reg  <= reg_en_next;
            wlan_reset_n_reg      <= wlan_rn_next;
            bt_reset_n_reg        <= bt_rn_next;
            por_reset_n_reg       <= por_ok_next;
            sdio_ready_reg        <= ready_next;
            restart_too_early_reg <= early_next;
        end
    end

    assign regulator_enable  = regulator_enable_reg;
    assign wlan_reset_n      = wlan_reset_n_reg;
    assign bt_reset_n        = bt_reset_n_reg;
    assign por_reset_n       = por_reset_n_reg;
    assign sdio_ready        = sdio_ready_reg;
    assign restart_too_early = restart_too_early_reg;

    // Checks

    // Cycles since reset release, so history taps start valid
    logic [1:0] age_reg;
    wire logic  aged = (age_reg == 2'h3);

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            age_reg <= 2'h0;
        end else if (!aged) begin
            age_reg <= age_reg + 2'h1;
        end
    end

    sync_path_a: assert property (
        @(posedge mclk) disable iff (!rstn)
        aged |-> (wl_s == $past(wlan_power_request, 2)) && (bt_s == $past(bt_power_request, 2))
    ) else $error("request synchroniser latency is not two cycles");

    regulator_or_a: assert property (
        @(posedge mclk) disable iff (!rstn)
        aged |-> regulator_enable == ($past(wlan_power_request, 3) | $past(bt_power_request, 3))
    ) else $error("regulator enable does not follow OR of requests");

    regulator_off_a: assert property (
        @(posedge mclk) disable iff (!rstn)
        (aged && !wl_s && !bt_s) |=> !regulator_enable
    ) else $error("regulators stay on with both requests low");

    wlan_release_a: assert property (
        @(posedge mclk) disable iff (!rstn)
        (aged && wl_s && por_ok_next) |=> (wlan_reset_n && regulator_enable)
    ) else $error("wlan not released or regulators off while requested");

    wlan_hold_a: assert property (
        @(posedge mclk) disable iff (!rstn)
        aged && !$past(wlan_power_request, 3) |-> !wlan_reset_n
    ) else $error("wlan out of reset while request low");

    bt_hold_a: assert property (
        @(posedge mclk) disable iff (!rstn)
        (wl_s && !bt_s) |=> (!bt_reset_n && regulator_enable)
    ) else $error("bluetooth out of reset while its request low");

    por_limit_a: assert property (
        @(posedge mclk) disable iff (!rstn)
        (state_reg == ST_HOLD) |-> (cnt_reg < POR_HOLD)
    ) else $error("power-on reset held beyond its limit");

    por_release_a: assert property (
        @(posedge mclk) disable iff (!rstn)
        (state_reg == ST_HOLD && hold_done && supplies_up) |=> por_reset_n
    ) else $error("power-on reset not released at end of hold");

    sdio_gate_a: assert property (
        @(posedge mclk) disable iff (!rstn)
        $rose(sdio_ready) |-> $past(state_reg == ST_SETTLE) && $past(wait_done) && por_reset_n
    ) else $error("host access ready raised before wait elapsed");

    early_flag_a: assert property (
        @(posedge mclk) disable iff (!rstn)
        restart_too_early |-> $past(any_on) && !$past(was_on_reg) && ($past(off_cnt_reg) < OFF_MIN)
    ) else $error("restart flag raised without a short off time");

    supply_drop_a: assert property (
        @(posedge mclk) disable iff (!rstn)
        !supplies_up |=> (!por_reset_n && !wlan_reset_n && !bt_reset_n && !sdio_ready)
    ) else $error("resets not asserted after supply loss");

    wlan_on_c: cover property (
        @(posedge mclk) disable iff (!rstn)
        $rose(wlan_reset_n)
    );

    bt_only_c: cover property (
        @(posedge mclk) disable iff (!rstn)
        bt_reset_n && !wlan_reset_n && regulator_enable
    );

    early_restart_c: cover property (
        @(posedge mclk) disable iff (!rstn)
        restart_too_early
    );

    sdio_ready_c: cover property (
        @(posedge mclk) disable iff (!rstn)
        $rose(sdio_ready)
    );

endmodule
`default_nettype wire

// ==== host_model.sv ====
// Host-side model that drives the two power-request lines
`timescale 1ns/1ps
`default_nettype none

module host_model #(
    parameter int unsigned OFF_MIN = 10
) (
    input  wire logic mclk,
    output logic      wlan_power_request,
    output logic      bt_power_request
);
    int unsigned off_cnt   = 0;
    logic        timed_out = 1'b0;

    initial begin
        wlan_power_request = 1'b0;
        bt_power_request   = 1'b0;
    end

    // Time spent with both lines low, so the buck can discharge
    always @(posedge mclk) begin
        if (!wlan_power_request && !bt_power_request) begin
            off_cnt <= off_cnt + 1;
        end else begin
            off_cnt <= 0;
        end
    end

    // FM use forces the Bluetooth line high; early skips the off wait on purpose
    task automatic request(input logic wl, input logic bt, input logic fm, input logic early);
        logic bt_eff;
        int   n;
        bt_eff = bt | fm;
        n      = 0;
        if (!early && !wlan_power_request && !bt_power_request) begin
            while (off_cnt < OFF_MIN && n < 1000) begin
                @(posedge mclk);
                n++;
            end
            // A wait that ran out is reported by the bench at the end
            if (off_cnt < OFF_MIN) begin
                timed_out = 1'b1;
            end
        end
        @(negedge mclk);
        wlan_power_request = wl;
        bt_power_request   = bt_eff;
    endtask
endmodule

`default_nettype wire

// ==== tb_top.sv ====
// Self-checking testbench for the radio power and reset sequencer
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    localparam int P_HOLD = 20;
    localparam int P_SDIO = 40;
    localparam int P_OFF  = 10;

    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic core_supply_good = 1'b0;
    logic io_supply_good   = 1'b0;
    wire  wl_req;
    wire  bt_req;
    logic regulator_enable;
    logic wlan_reset_n;
    logic bt_reset_n;
    logic por_reset_n;
    logic sdio_ready;
    logic restart_too_early;
    int   bad_count   = 0;
    int   check_count = 0;

    always #12.5 mclk = ~mclk;

    host_model #(.OFF_MIN(P_OFF)) host_u (
        .mclk               (mclk),
        .wlan_power_request (wl_req),
        .bt_power_request   (bt_req)
    );

    radio_power_reset_sequencer #(
        .POR_HOLD (23'(P_HOLD)),
        .SDIO_WAIT(23'(P_SDIO)),
        .OFF_MIN  (23'(P_OFF))
    ) dut_u (
        .mclk               (mclk),
        .rstn               (rstn),
        .wlan_power_request (wl_req),
        .bt_power_request   (bt_req),
        .core_supply_good   (core_supply_good),
        .io_supply_good     (io_supply_good),
        .regulator_enable   (regulator_enable),
        .wlan_reset_n       (wlan_reset_n),
        .bt_reset_n         (bt_reset_n),
        .por_reset_n        (por_reset_n),
        .sdio_ready         (sdio_ready),
        .restart_too_early  (restart_too_early)
    );

    task automatic final_report();
        check("host_off_wait", host_u.timed_out, 1'b0);
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic seen, input logic exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %b seen %b", name, exp, seen);
        end
    endtask

    task automatic edges(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic expect_out(input logic reg_e, input logic wl_e, input logic bt_e);
        check("regulator_enable", regulator_enable, reg_e);
        check("wlan_reset_n", wlan_reset_n, wl_e);
        check("bt_reset_n", bt_reset_n, bt_e);
    endtask

    // Regulators come up before the power-on hold ends; sections wait for it
    task automatic s_power_on();
        int kp;
        int ks;
        kp = 0;
        ks = 0;
        host_u.request(1'b1, 1'b0, 1'b0, 1'b0);
        edges(3);
        expect_out(1'b1, 1'b0, 1'b0);
        core_supply_good = 1'b1;
        io_supply_good   = 1'b1;
        for (int k = 1; k <= 200 && ks == 0; k++) begin
            @(negedge mclk);
            if (kp == 0 && por_reset_n === 1'b1) kp = k;
            if (ks == 0 && sdio_ready === 1'b1) ks = k;
        end
        if (ks == 0) begin
            check("sdio_ready", sdio_ready, 1'b1);
            final_report();
        end
        check("por_hold", kp >= P_HOLD && kp <= P_HOLD + 2, 1'b1);
        check("sdio_wait", ks >= P_SDIO && ks <= P_SDIO + 2, 1'b1);
        expect_out(1'b1, 1'b1, 1'b0);
    endtask

    // Swap to Bluetooth only; the synchroniser delays the change
    task automatic s_bt_only();
        host_u.request(1'b0, 1'b1, 1'b0, 1'b0);
        edges(1);
        check("wlan_reset_n", wlan_reset_n, 1'b1);
        edges(2);
        expect_out(1'b1, 1'b0, 1'b1);
        host_u.request(1'b1, 1'b0, 1'b1, 1'b0);
        edges(3);
        expect_out(1'b1, 1'b1, 1'b1);
    endtask

    task automatic count_pulses(output int n);
        n = 0;
        repeat (8) begin
            @(negedge mclk);
            if (restart_too_early === 1'b1) n++;
        end
    endtask

    // Off time kept, then broken on purpose
    task automatic s_off_time();
        int n;
        host_u.request(1'b0, 1'b0, 1'b0, 1'b0);
        edges(3);
        expect_out(1'b0, 1'b0, 1'b0);
        host_u.request(1'b1, 1'b0, 1'b0, 1'b0);
        count_pulses(n);
        check("late_restart", n == 0, 1'b1);
        check("regulator_enable", regulator_enable, 1'b1);
        host_u.request(1'b0, 1'b0, 1'b0, 1'b0);
        edges(3);
        host_u.request(1'b0, 1'b1, 1'b0, 1'b1);
        count_pulses(n);
        check("early_restart", n == 1, 1'b1);
        expect_out(1'b1, 1'b0, 1'b1);
    endtask

    // A reset in mid-run clears every output, and the full off count it loads leaves no false restart behind
    task automatic s_mid_reset();
        int n;
        int kp;
        kp = 0;
        rstn = 1'b0;
        edges(1);
        expect_out(1'b0, 1'b0, 1'b0);
        check("por_reset_n", por_reset_n, 1'b0);
        edges(1);
        rstn = 1'b1;
        count_pulses(n);
        check("reset_restart", n == 0, 1'b1);
        check("regulator_enable", regulator_enable, 1'b1);
        for (int k = 9; k <= 60 && kp == 0; k++) begin
            @(negedge mclk);
            if (por_reset_n === 1'b1) kp = k;
        end
        check("por_rehold", kp >= P_HOLD && kp <= P_HOLD + 2, 1'b1);
        if (kp == 0) begin
            final_report();
        end
        expect_out(1'b1, 1'b0, 1'b1);
    endtask

    // A supply drop puts every section back in reset at once
    task automatic s_supply_drop();
        core_supply_good = 1'b0;
        edges(1);
        check("por_reset_n", por_reset_n, 1'b0);
        check("sdio_ready", sdio_ready, 1'b0);
        expect_out(1'b1, 1'b0, 1'b0);
    endtask

    initial begin
        edges(10);
        rstn = 1'b1;
        edges(1);
        s_power_on();
        s_bt_only();
        s_off_time();
        s_mid_reset();
        s_supply_drop();
        final_report();
    end
endmodule

`default_nettype wire
